// File: verilog/adc_ctrl_pkg.sv
// adc_ctrl_pkg: register map, field positions, reset values and sequencer
// states shared by the converter start and interrupt control block.
// assumes a 32-bit apb register bus with word-aligned byte addresses.
`default_nettype none

package adc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CHSEL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_MASK = 12'h00c;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_START_POS = 0;
  localparam int CTRL_SCAN_POS = 1;
  localparam int EV_EOC_POS = 0;
  localparam int EV_WRAP_POS = 1;
  localparam int EV_W = 2;
  localparam int STAT_BUSY_POS = 4;
  localparam int STAT_CHAN_POS = 8;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CHSEL_RST = 32'h0000_0001;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic {SEQ_IDLE, SEQ_BUSY} seq_state_t;

endpackage
`default_nettype wire

// File: verilog/adc_irq_status.sv
// adc_irq_status: sticky event flags, their mask and the level interrupt.
// assumes events and clears arrive as one-cycle pulses on pclk.
`timescale 1ns/1ps
`default_nettype none

module adc_irq_status #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events and clears
  input wire logic [W-1:0] ev,
  input wire logic [W-1:0] clr,
  // mask write
  input wire logic mask_wr,
  input wire logic [W-1:0] mask_wdata,
  // state
  output logic [W-1:0] status_r,
  output logic [W-1:0] mask_r,
  output logic irq_r
);

  logic [W-1:0] status_nxt;
  logic [W-1:0] mask_nxt;

  // set wins over a read clear in the same cycle so no event is lost
  always_comb begin
    status_nxt = (status_r & ~clr) | ev;
    mask_nxt = mask_wr ? mask_wdata : mask_r;
  end

  // flags and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= adc_ctrl_pkg::STATUS_RST[W-1:0];
      mask_r <= adc_ctrl_pkg::MASK_RST[W-1:0];
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
    end
  end

  // irq from next values keeps it aligned with the flag registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  eoc_irq_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_r[adc_ctrl_pkg::EV_EOC_POS] && mask_r[adc_ctrl_pkg::EV_EOC_POS] |-> irq_r)
    else $error("end flag enabled but no interrupt");

  irq_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(status_r & mask_r)) |-> !irq_r)
    else $error("interrupt raised while disabled");

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev[adc_ctrl_pkg::EV_EOC_POS] |=> status_r[adc_ctrl_pkg::EV_EOC_POS])
    else $error("end event lost");

endmodule
`default_nettype wire

// File: verilog/adc_sequencer.sv
// adc_sequencer: starts conversions, steps through the selected channels.
// assumes conv_done is a one-cycle pulse from the converter on pclk.
`timescale 1ns/1ps
`default_nettype none

module adc_sequencer #(
  parameter int NCH = 4,
  parameter int CW = (NCH > 1) ? $clog2(NCH) : 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic scan,
  input wire logic [NCH-1:0] chan_mask,
  // converter
  input wire logic conv_done,
  output logic conv_start_r,
  output logic [CW-1:0] chan_r,
  // events
  output logic eoc_r,
  output logic wrap_r,
  output logic single_end_r,
  output logic busy_r
);

  adc_ctrl_pkg::seq_state_t state_r;
  logic [CW-1:0] nxt_ch;

  // lowest selected channel; channel 0 when nothing is selected
  function automatic logic [CW-1:0] first_ch(input logic [NCH-1:0] m);
    logic [CW-1:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i]) r = CW'(i);
    end
    return r;
  endfunction

  // next selected channel after cur, cyclic
  function automatic logic [CW-1:0] next_ch(input logic [NCH-1:0] m,
                                            input logic [CW-1:0] cur);
    logic [CW-1:0] r;
    int idx;
    r = cur;
    idx = 0;
    for (int i = NCH - 1; i >= 1; i--) begin
      idx = (int'(cur) + i) % NCH;
      if (m[idx]) r = CW'(idx);
    end
    return r;
  endfunction

  always_comb begin
    nxt_ch = next_ch(chan_mask, chan_r);
  end

  // conversion control; single_end_r blocks a restart before run drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= adc_ctrl_pkg::SEQ_IDLE;
      chan_r <= '0;
      conv_start_r <= 1'b0;
      eoc_r <= 1'b0;
      wrap_r <= 1'b0;
      single_end_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      eoc_r <= 1'b0;
      wrap_r <= 1'b0;
      single_end_r <= 1'b0;
      unique case (state_r)
        adc_ctrl_pkg::SEQ_IDLE: begin
          if (run && !single_end_r) begin
            state_r <= adc_ctrl_pkg::SEQ_BUSY;
            busy_r <= 1'b1;
            chan_r <= first_ch(chan_mask);
            conv_start_r <= 1'b1;
          end
        end
        adc_ctrl_pkg::SEQ_BUSY: begin
          if (!run) begin
            // abandon the conversion in flight; its done pulse is ignored
            state_r <= adc_ctrl_pkg::SEQ_IDLE;
            busy_r <= 1'b0;
          end else if (conv_done) begin
            eoc_r <= 1'b1;
            if (scan) begin
              chan_r <= nxt_ch;
              conv_start_r <= 1'b1;
              wrap_r <= (nxt_ch <= chan_r);
            end else begin
              state_r <= adc_ctrl_pkg::SEQ_IDLE;
              busy_r <= 1'b0;
              single_end_r <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  sequence start_seq;
    state_r == adc_ctrl_pkg::SEQ_IDLE && run && !single_end_r;
  endsequence

  sequence scan_step;
    state_r == adc_ctrl_pkg::SEQ_BUSY && run && scan && conv_done;
  endsequence

  sequence single_step;
    state_r == adc_ctrl_pkg::SEQ_BUSY && run && !scan && conv_done;
  endsequence

  stop_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> !conv_start_r && state_r == adc_ctrl_pkg::SEQ_IDLE)
    else $error("converter active while start bit is 0");

  run_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_seq |=> conv_start_r && busy_r)
    else $error("no conversion after start");

  scan_repeat_a: assert property (@(posedge pclk) disable iff (!presetn)
    scan_step |=> conv_start_r && eoc_r && busy_r && chan_r == $past(nxt_ch))
    else $error("scan did not step to next channel");

  single_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    single_step |=> single_end_r && !conv_start_r ##1 !conv_start_r)
    else $error("single conversion did not end");

endmodule
`default_nettype wire

// File: verilog/adc_start_ctrl.sv
// adc_start_ctrl: apb register file for conversion start, mode, channel
// selection and end-of-conversion interrupt, around the sequencer.
// assumes standby_req and conv_done come from logic on pclk.
//
// How it works
// - start bit at 0 keeps the converter idle, no conversion.
// - single mode: start bit 1 runs one conversion, then self-clears.
// - scan mode: start bit 1 converts repeatedly, cycling selected channels.
// - scan stops only when start clears: software, reset or standby.
// - interrupt enable 0 suppresses the end request, 1 allows it.
`timescale 1ns/1ps
`default_nettype none

module adc_start_ctrl #(
  parameter int NCH = 4,
  parameter int CW = (NCH > 1) ? $clog2(NCH) : 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  // power control
  input wire logic standby_req,
  // converter
  input wire logic conv_done,
  output logic conv_start_r,
  output logic [CW-1:0] conv_chan_r,
  // interrupt
  output logic irq_r
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic start_r;
  logic scan_r;
  logic [NCH-1:0] chsel_r;
  logic setup_acc;
  logic done_acc;
  logic ctrl_wr;
  logic chsel_wr;
  logic mask_wr;
  logic stat_rd;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [adc_ctrl_pkg::EV_W-1:0] ev;
  logic [adc_ctrl_pkg::EV_W-1:0] clr;
  logic [adc_ctrl_pkg::EV_W-1:0] status_r;
  logic [adc_ctrl_pkg::EV_W-1:0] mask_r;
  logic eoc;
  logic wrap;
  logic single_end;
  logic busy;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------

  // one wait state: pready rises in the second access cycle
  always_comb begin
    setup_acc = psel && penable && !pready_r;
    done_acc = psel && penable && pready_r;
    ctrl_wr = done_acc && pwrite && (paddr == adc_ctrl_pkg::OFS_CTRL);
    chsel_wr = done_acc && pwrite && (paddr == adc_ctrl_pkg::OFS_CHSEL);
    mask_wr = done_acc && pwrite && (paddr == adc_ctrl_pkg::OFS_MASK);
    stat_rd = done_acc && !pwrite && (paddr == adc_ctrl_pkg::OFS_STATUS);
    addr_ok = (paddr == adc_ctrl_pkg::OFS_CTRL) ||
              (paddr == adc_ctrl_pkg::OFS_CHSEL) ||
              (paddr == adc_ctrl_pkg::OFS_STATUS) ||
              (paddr == adc_ctrl_pkg::OFS_MASK);
  end

  // read mux; unused bits read zero, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      adc_ctrl_pkg::OFS_CTRL: begin
        rd_mux[adc_ctrl_pkg::CTRL_START_POS] = start_r;
        rd_mux[adc_ctrl_pkg::CTRL_SCAN_POS] = scan_r;
      end
      adc_ctrl_pkg::OFS_CHSEL: begin
        rd_mux[NCH-1:0] = chsel_r;
      end
      adc_ctrl_pkg::OFS_STATUS: begin
        rd_mux[adc_ctrl_pkg::EV_W-1:0] = status_r;
        rd_mux[adc_ctrl_pkg::STAT_BUSY_POS] = busy;
        rd_mux[adc_ctrl_pkg::STAT_CHAN_POS +: CW] = conv_chan_r;
      end
      adc_ctrl_pkg::OFS_MASK: begin
        rd_mux[adc_ctrl_pkg::EV_W-1:0] = mask_r;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // response flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_acc;
      if (setup_acc) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_r <= !addr_ok;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------

  // standby beats a software write; a write beats the self-clear so a
  // restart issued as the last conversion ends is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= adc_ctrl_pkg::CTRL_RST[adc_ctrl_pkg::CTRL_START_POS];
    end else if (standby_req) begin
      start_r <= 1'b0;
    end else if (ctrl_wr) begin
      start_r <= pwdata[adc_ctrl_pkg::CTRL_START_POS];
    end else if (single_end) begin
      start_r <= 1'b0;
    end
  end

  // mode bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_r <= adc_ctrl_pkg::CTRL_RST[adc_ctrl_pkg::CTRL_SCAN_POS];
    end else if (ctrl_wr) begin
      scan_r <= pwdata[adc_ctrl_pkg::CTRL_SCAN_POS];
    end
  end

  // channel selection; takes effect at the next channel step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chsel_r <= adc_ctrl_pkg::CHSEL_RST[NCH-1:0];
    end else if (chsel_wr) begin
      chsel_r <= pwdata[NCH-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  adc_sequencer #(
    .NCH(NCH),
    .CW(CW)
  ) adc_sequencer_inst (
    .pclk(pclk),
    .presetn(presetn),
    .run(start_r),
    .scan(scan_r),
    .chan_mask(chsel_r),
    .conv_done(conv_done),
    .conv_start_r(conv_start_r),
    .chan_r(conv_chan_r),
    .eoc_r(eoc),
    .wrap_r(wrap),
    .single_end_r(single_end),
    .busy_r(busy)
  );

  // ----------------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------------

  // clear only the bits the read returned; later events survive
  always_comb begin
    ev = '0;
    ev[adc_ctrl_pkg::EV_EOC_POS] = eoc;
    ev[adc_ctrl_pkg::EV_WRAP_POS] = wrap;
    clr = stat_rd ? prdata_r[adc_ctrl_pkg::EV_W-1:0] : '0;
  end

  adc_irq_status #(
    .W(adc_ctrl_pkg::EV_W)
  ) adc_irq_status_inst (
    .pclk(pclk),
    .presetn(presetn),
    .ev(ev),
    .clr(clr),
    .mask_wr(mask_wr),
    .mask_wdata(pwdata[adc_ctrl_pkg::EV_W-1:0]),
    .status_r(status_r),
    .mask_r(mask_r),
    .irq_r(irq_r)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // scan keeps its start bit until software or standby clears it
  scan_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_r && scan_r && !standby_req && !ctrl_wr |=> start_r)
    else $error("scan stopped without a clear");

  // standby clears start at once and no new conversion follows
  standby_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    standby_req |=> !start_r ##1 !conv_start_r)
    else $error("standby did not stop conversion");

  // a finished single conversion drops the start bit by itself
  single_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    single_end && !ctrl_wr && !standby_req |=> !start_r)
    else $error("start bit not cleared after single conversion");

  // an enabled end event reaches the request one edge later
  eoc_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    eoc && mask_r[adc_ctrl_pkg::EV_EOC_POS] && !mask_wr |=> irq_r)
    else $error("enabled end of conversion gave no interrupt");

  // with every enable at 0 the request never rises
  eoc_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !mask_r[adc_ctrl_pkg::EV_EOC_POS] && !mask_r[adc_ctrl_pkg::EV_WRAP_POS] |-> !irq_r)
    else $error("interrupt while all enables are 0");

  // exactly one wait state; software timing never depends on more
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready_r |=> pready_r)
    else $error("apb answer late");

  // ----------------------------------------------------------------------
  // bus and register checks
  // ----------------------------------------------------------------------

  // apb steps as the slave sees them: first access cycle, answer cycle
  sequence apb_first;
    psel && penable && !pready_r;
  endsequence

  sequence apb_last;
    psel && penable && pready_r;
  endsequence

  // a completed control write that does not clash with standby
  sequence ctrl_write;
    apb_last ##0 (pwrite && paddr == adc_ctrl_pkg::OFS_CTRL && !standby_req);
  endsequence

  // a completed status read whose data carried the end flag
  sequence eoc_read;
    apb_last ##0 (!pwrite && paddr == adc_ctrl_pkg::OFS_STATUS &&
      prdata_r[adc_ctrl_pkg::EV_EOC_POS]);
  endsequence

  // the answer lasts one cycle, so a stuck ready cannot swallow a transfer
  rdy_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready_r |=> !pready_r)
    else $error("apb ready held too long");

  // an error is only ever shown together with the answer
  err_with_rdy_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_r |-> pready_r)
    else $error("apb error without ready");

  // writes return zero data
  wr_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_first ##0 pwrite |=> prdata_r == 32'h0000_0000)
    else $error("write returned data");

  // an unaligned address never maps: error and zero data
  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_first ##0 (paddr[1:0] != 2'b00) |=> pslverr_r && prdata_r == 32'h0000_0000)
    else $error("unaligned access not refused");

  // a software write of the start bit lands, even over the self-clear
  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_write |=> start_r == $past(pwdata[adc_ctrl_pkg::CTRL_START_POS]))
    else $error("start bit write lost");

  // a channel selection write lands
  chsel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_last ##0 (pwrite && paddr == adc_ctrl_pkg::OFS_CHSEL) |=>
      chsel_r == $past(pwdata[NCH-1:0]))
    else $error("channel selection write lost");

  // a read clears the end flag it returned unless a new end arrives
  stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    eoc_read ##0 !eoc |=> !status_r[adc_ctrl_pkg::EV_EOC_POS])
    else $error("end flag survived its read");

  // start bit at 0 never launches a conversion
  start_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    !start_r |=> !conv_start_r)
    else $error("conversion launched with start bit 0");

  // scan keeps converting while the start bit stays set
  scan_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_r && scan_r && busy && conv_done |=> conv_start_r)
    else $error("scan did not continue");

endmodule
`default_nettype wire

// File: dv/adc_start_ctrl_test.sv
// adc_start_ctrl_test: self-checking bench for the converter start and
// interrupt control; it drives apb, conv_done and standby_req itself.
// assumes the design answers apb with pready_r and pulses conv_start_r.
`timescale 1ns/1ps
`default_nettype none

module adc_start_ctrl_test;
  // ----------------------------------------------------------------------
  // clock, reset and design hookup
  // ----------------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic standby_req = 1'b0;
  logic conv_done = 1'b0;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic conv_start_r;
  logic [1:0] conv_chan_r;
  logic irq_r;
  int error_cnt = 0;
  int checked = 0;
  int starts = 0;
  int cycles = 0;

  always #12.5 pclk = ~pclk;

  adc_start_ctrl #(.NCH(4)) adc_start_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .standby_req(standby_req), .conv_done(conv_done), .conv_start_r(conv_start_r),
    .conv_chan_r(conv_chan_r), .irq_r(irq_r));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; entered just after an edge, holds until pready_r
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here: only the bench timeout ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready_r !== 1'b1);
    rd = prdata_r;
    err = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0000_0000, rd, e);
    chk(rd & m, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic pulse_done();
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask

  // waits for a start pulse, checks its channel, optionally finishes it
  task automatic conv(input logic [1:0] ch, input logic done);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_start_r !== 1'b1 && n < 50);
    chk({29'h0, conv_start_r, conv_chan_r}, {29'h0, 1'b1, ch});
    if (done) begin
      pulse_done();
    end
  endtask

  // counts start pulses; the ceiling is far above the few hundred needed
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (conv_start_r === 1'b1) begin
      starts <= starts + 1;
    end
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // ordinary cases: reset values and register map
  // ----------------------------------------------------------------------
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] rd; logic err;} row_t;
  row_t rows [10] = '{
    '{1'b0, adc_ctrl_pkg::OFS_CTRL, 32'h0, adc_ctrl_pkg::CTRL_RST, 1'b0},
    '{1'b0, adc_ctrl_pkg::OFS_CHSEL, 32'h0, adc_ctrl_pkg::CHSEL_RST, 1'b0},
    '{1'b0, adc_ctrl_pkg::OFS_STATUS, 32'h0, adc_ctrl_pkg::STATUS_RST, 1'b0},
    '{1'b0, adc_ctrl_pkg::OFS_MASK, 32'h0, adc_ctrl_pkg::MASK_RST, 1'b0},
    '{1'b1, adc_ctrl_pkg::OFS_MASK, 32'h3, 32'h0, 1'b0},
    '{1'b0, adc_ctrl_pkg::OFS_MASK, 32'h0, 32'h3, 1'b0},
    '{1'b1, 12'h010, 32'h1, 32'h0, 1'b1},
    '{1'b0, 12'h002, 32'h0, 32'h0, 1'b1},
    '{1'b1, adc_ctrl_pkg::OFS_STATUS, 32'hff, 32'h0, 1'b0},
    '{1'b1, adc_ctrl_pkg::OFS_MASK, 32'h0, 32'h0, 1'b0}};

  initial begin
    logic [31:0] rd;
    logic e;
    int s;
    logic [1:0] seq [5];
    // driven from x so the design sees a real falling edge of reset
    presetn <= 1'b0;
    seq = '{2'd1, 2'd3, 2'd1, 2'd3, 2'd1};
    idle(20);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, e);
      chk(rd, rows[i].rd);
      chk({31'h0, e}, {31'h0, rows[i].err});
    end
    rd_chk(adc_ctrl_pkg::OFS_STATUS, 32'h0, 32'hffff_ffff);
    $display("test register map done");
    // start bit left at 0, scan mode selected: nothing may start
    wr(adc_ctrl_pkg::OFS_CTRL, 32'h2);
    idle(30);
    chk(starts, 0);
    $display("test idle done");
    // single mode with the interrupt enabled
    wr(adc_ctrl_pkg::OFS_MASK, 32'h1);
    wr(adc_ctrl_pkg::OFS_CTRL, 32'h1);
    conv(2'd0, 1'b1);
    idle(4);
    chk(irq_r, 1'b1);
    rd_chk(adc_ctrl_pkg::OFS_CTRL, 32'h0, 32'h1);
    rd_chk(adc_ctrl_pkg::OFS_STATUS, 32'h1, 32'h1);
    idle(2);
    chk(irq_r, 1'b0);
    chk(starts, 1);
    $display("test single done");
    // enable off: flag sets but request stays low until enabled
    wr(adc_ctrl_pkg::OFS_MASK, 32'h0);
    wr(adc_ctrl_pkg::OFS_CTRL, 32'h1);
    conv(2'd0, 1'b1);
    idle(4);
    chk(irq_r, 1'b0);
    wr(adc_ctrl_pkg::OFS_MASK, 32'h1);
    idle(2);
    chk(irq_r, 1'b1);
    rd_chk(adc_ctrl_pkg::OFS_STATUS, 32'h1, 32'h1);
    idle(2);
    chk(irq_r, 1'b0);
    $display("test enable done");
    // scan over channels 1 and 3, then stop by software mid-conversion
    wr(adc_ctrl_pkg::OFS_CHSEL, 32'ha);
    wr(adc_ctrl_pkg::OFS_CTRL, 32'h3);
    for (int i = 0; i < 5; i++) begin
      conv(seq[i], i < 4);
    end
    wr(adc_ctrl_pkg::OFS_CTRL, 32'h2);
    idle(2);
    s = starts;
    pulse_done();
    idle(30);
    chk(starts, s);
    $display("test scan and software stop done");
    // single channel so the restart channel is fixed; standby stops scan
    wr(adc_ctrl_pkg::OFS_CHSEL, 32'h4);
    wr(adc_ctrl_pkg::OFS_CTRL, 32'h3);
    conv(2'd2, 1'b0);
    standby_req <= 1'b1;
    idle(1);
    standby_req <= 1'b0;
    idle(2);
    s = starts;
    rd_chk(adc_ctrl_pkg::OFS_CTRL, 32'h0, 32'h1);
    pulse_done();
    idle(30);
    chk(starts, s);
    $display("test standby stop done");
    // reset in mid-scan clears the start bit
    wr(adc_ctrl_pkg::OFS_CTRL, 32'h3);
    conv(2'd2, 1'b0);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    s = starts;
    rd_chk(adc_ctrl_pkg::OFS_CTRL, 32'h0, 32'h3);
    idle(30);
    chk(starts, s);
    $display("test reset stop done");
    conclude();
  end
endmodule

`default_nettype wire
